// file: src/gpr_top.sv
// GPIO ports A to D, aux pin-change port and control register behind Wishbone
`timescale 1ns/10ps
module gpr_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gpr_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [gpr_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [gpr_pkg::DAT_W-1:0] wb_dat_i,
  output logic [gpr_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Port A pins
  input wire logic [7:0] port_a_pin,
  output logic [7:0] port_a_drive,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_pullup,
  // Port B pins
  input wire logic [7:0] port_b_pin,
  output logic [7:0] port_b_drive,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  // Port C pins
  input wire logic [7:0] port_c_pin,
  output logic [7:0] port_c_drive,
  output logic [7:0] port_c_oe,
  output logic [7:0] port_c_pullup,
  // Port D pins
  input wire logic [7:0] port_d_pin,
  output logic [7:0] port_d_drive,
  output logic [7:0] port_d_oe,
  output logic [7:0] port_d_pullup,
  // Aux pin-change port pins
  input wire logic [7:0] aux_pin,
  output logic [7:0] aux_drive,
  output logic [7:0] aux_oe,
  output logic [7:0] aux_pullup,
  // Power state
  input wire logic sleep_mode,
  // Pin-change events and interrupt
  output logic [gpr_pkg::PC_NUM-1:0] pin_change_evt,
  output logic irq,
  // Control bits for other blocks
  output logic debug_port_disable,
  output logic vector_table_select,
  output logic vector_change_enable
);

  gpr_pkg::gpr_regs_s r;
  gpr_pkg::gpr_regs_s n;

  logic [gpr_pkg::IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic [gpr_pkg::PORT_W-1:0] rdata;
  logic [gpr_pkg::PORT_W-1:0] wbyte;
  logic [gpr_pkg::PC_NUM-1:0] pc_raw;
  logic [gpr_pkg::SYNC_W-1:0] sync_raw;
  logic [gpr_pkg::SYNC_W-1:0] sync_out;

  // Pad arrays, index 4 is the aux port
  logic [gpr_pkg::NUM_PADS-1:0][7:0] pad_pin;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] pad_dir;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] pad_latch;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] pad_drive;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] pad_oe;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] pad_pullup;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] pad_din;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_pu_en;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_pu_val;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_dd_en;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_dd_val;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_pv_en;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_pv_val;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_die_en;
  logic [gpr_pkg::NUM_PADS-1:0][7:0] ov_die_val;
  logic [7:0] aux_stable;

  // All pins pass the three-stage synchroniser
  assign sync_raw = {aux_pin, port_d_pin, port_c_pin, port_b_pin, port_a_pin};

  gpr_sync #(
    .W(gpr_pkg::SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw(sync_raw),
    .settled(sync_out)
  );

  assign pad_pin = sync_out;
  assign aux_stable = pad_pin[gpr_pkg::AUX_PAD];

  // Register values feeding the pads
  assign pad_dir = {r.aux_dir, r.dir};
  assign pad_latch = {r.aux_out, r.out};

  // Ports A to D have no overrides in this block
  assign ov_pu_en = '0;
  assign ov_pu_val = '0;
  assign ov_dd_en = '0;
  assign ov_dd_val = '0;
  assign ov_pv_en = '0;
  assign ov_pv_val = '0;
  assign ov_die_val = '0;

  // Input-enable override: pins 6..0 follow mask AND group enable, bit 7 none
  assign ov_die_en[gpr_pkg::NUM_PORTS-1:0] = '0;
  assign ov_die_en[gpr_pkg::AUX_PAD] = {1'b0, r.pc_mask & {gpr_pkg::PC_NUM{r.pc_ge}}};

  // Pad logic of all five ports
  for (genvar p = 0; p < gpr_pkg::NUM_PADS; p++) begin : g_pad
    gpr_pad u_pad (
      .direction_bit(pad_dir[p]),
      .output_latch_bit(pad_latch[p]),
      .pullup_kill_bit(r.ctrl[gpr_pkg::CTRL_PULLUP_KILL_BIT]),
      .sleep_mode(sleep_mode),
      .pullup_override_enable(ov_pu_en[p]),
      .pullup_override_value(ov_pu_val[p]),
      .direction_override_enable(ov_dd_en[p]),
      .direction_override_value(ov_dd_val[p]),
      .outval_override_enable(ov_pv_en[p]),
      .outval_override_value(ov_pv_val[p]),
      .input_enable_override_enable(ov_die_en[p]),
      .input_enable_override_value(ov_die_val[p]),
      .pin_level(pad_pin[p]),
      .pin_drive(pad_drive[p]),
      .pin_oe(pad_oe[p]),
      .pin_pullup(pad_pullup[p]),
      .pin_din(pad_din[p])
    );
  end

  // Pin outputs
  assign port_a_drive = pad_drive[0];
  assign port_a_oe = pad_oe[0];
  assign port_a_pullup = pad_pullup[0];
  assign port_b_drive = pad_drive[1];
  assign port_b_oe = pad_oe[1];
  assign port_b_pullup = pad_pullup[1];
  assign port_c_drive = pad_drive[2];
  assign port_c_oe = pad_oe[2];
  assign port_c_pullup = pad_pullup[2];
  assign port_d_drive = pad_drive[3];
  assign port_d_oe = pad_oe[3];
  assign port_d_pullup = pad_pullup[3];
  assign aux_drive = pad_drive[gpr_pkg::AUX_PAD];
  assign aux_oe = pad_oe[gpr_pkg::AUX_PAD];
  assign aux_pullup = pad_pullup[gpr_pkg::AUX_PAD];

  // Bus request decode
  assign idx = wb_adr_i[gpr_pkg::ADR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i & ~r.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wbyte = wb_dat_i[gpr_pkg::PORT_W-1:0];

  // Level change on an enabled source pin, bit n is source 24+n
  assign pc_raw = (aux_stable[gpr_pkg::PC_NUM-1:0] ^ r.aux_prev) & r.pc_mask
                  & {gpr_pkg::PC_NUM{r.pc_ge}};

  // Next-state logic: register writes, read mux, events
  always_comb begin
    n = r;
    rdata = '0;
    for (int p = 0; p < gpr_pkg::NUM_PORTS; p++) begin
      if (idx == gpr_pkg::IDX_PORT_IN[p]) begin
        rdata = pad_din[p];
        if (wr) begin
          n.out[p] = r.out[p] ^ wbyte;
        end
      end
      if (idx == gpr_pkg::IDX_PORT_DIR[p]) begin
        rdata = r.dir[p];
        if (wr) begin
          n.dir[p] = wbyte;
        end
      end
      if (idx == gpr_pkg::IDX_PORT_OUT[p]) begin
        rdata = r.out[p];
        if (wr) begin
          n.out[p] = wbyte;
        end
      end
    end
    case (idx)
      gpr_pkg::IDX_CTRL: begin
        rdata = r.ctrl;
        if (wr) begin
          n.ctrl = wbyte & gpr_pkg::CTRL_RW_MASK;
        end
      end
      gpr_pkg::IDX_AUX_IN: begin
        rdata = pad_din[gpr_pkg::AUX_PAD] & gpr_pkg::AUX_RW_MASK;
        if (wr) begin
          n.aux_out = (r.aux_out ^ wbyte) & gpr_pkg::AUX_RW_MASK;
        end
      end
      gpr_pkg::IDX_AUX_DIR: begin
        rdata = r.aux_dir;
        if (wr) begin
          n.aux_dir = wbyte & gpr_pkg::AUX_RW_MASK;
        end
      end
      gpr_pkg::IDX_AUX_OUT: begin
        rdata = r.aux_out;
        if (wr) begin
          n.aux_out = wbyte & gpr_pkg::AUX_RW_MASK;
        end
      end
      gpr_pkg::IDX_PC_MASK: begin
        rdata = {1'b0, r.pc_mask};
        if (wr) begin
          n.pc_mask = wbyte[gpr_pkg::PC_NUM-1:0];
        end
      end
      gpr_pkg::IDX_PC_CTRL: begin
        rdata = {7'h00, r.pc_ge};
        if (wr) begin
          n.pc_ge = wbyte[gpr_pkg::PC_GE_BIT];
        end
      end
      gpr_pkg::IDX_IRQ_STAT: begin
        rdata = {1'b0, r.stat};
        if (rd) begin
          n.stat = '0;
        end
      end
      gpr_pkg::IDX_IRQ_MASK: begin
        rdata = {1'b0, r.imask};
        if (wr) begin
          n.imask = wbyte[gpr_pkg::PC_NUM-1:0];
        end
      end
      default: begin
        rdata = rdata;
      end
    endcase
    // A new event wins over a clearing read in the same cycle
    n.stat = n.stat | pc_raw;
    n.evt = pc_raw;
    n.aux_prev = aux_stable[gpr_pkg::PC_NUM-1:0];
    n.ack = req;
    n.rdat = rd ? {{(gpr_pkg::DAT_W - gpr_pkg::PORT_W){1'b0}}, rdata} : '0;
  end

  // State register; all fields reset to zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs from state
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign pin_change_evt = r.evt;
  assign irq = |(r.stat & r.imask);
  assign debug_port_disable = r.ctrl[gpr_pkg::CTRL_DBG_BIT];
  assign vector_table_select = r.ctrl[gpr_pkg::CTRL_VSEL_BIT];
  assign vector_change_enable = r.ctrl[gpr_pkg::CTRL_VCE_BIT];

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_src_map: assert property ((pc_raw != '0) |=> ((r.stat & $past(pc_raw)) == $past(pc_raw)))
    else $error("pin-change source did not set its status bit");

  a_aux_no_ov: assert property (aux_pullup == (~r.aux_dir & r.aux_out
    & {8{~r.ctrl[gpr_pkg::CTRL_PULLUP_KILL_BIT]}}) && aux_oe == r.aux_dir && aux_drive == r.aux_out)
    else $error("aux pin shows an override of pull-up, direction or value");

  a_die_gate: assert property (r.pc_ge |-> ((pad_din[gpr_pkg::AUX_PAD][6:0] & r.pc_mask) == 7'h00))
    else $error("enabled pin-change input not overridden");

  a_bit7_none: assert property (!sleep_mode |-> (aux_oe[7] == 1'b0 && aux_pullup[7] == 1'b0
    && pad_din[gpr_pkg::AUX_PAD][7] == aux_stable[7]))
    else $error("aux bit 7 shows an alternate function");

  a_pullup_kill: assert property (r.ctrl[gpr_pkg::CTRL_PULLUP_KILL_BIT] |-> (port_a_pullup == 8'h00
    && port_b_pullup == 8'h00 && port_c_pullup == 8'h00 && port_d_pullup == 8'h00 && aux_pullup == 8'h00))
    else $error("pull-up active while killed");

  a_ctrl_mask: assert property ((wr && idx == gpr_pkg::IDX_CTRL) |=> r.ctrl == ($past(wbyte) & 8'h93))
    else $error("control register write mask wrong");

  a_out_write: assert property ((wr && idx == gpr_pkg::IDX_PORT_OUT[0]) |=> port_a_drive == $past(wbyte))
    else $error("port A latch write not on pins");

  a_dir_write: assert property ((wr && idx == gpr_pkg::IDX_PORT_DIR[1]) |=> port_b_oe == $past(wbyte))
    else $error("port B direction write not on enables");

  a_in_read: assert property ((rd && idx == gpr_pkg::IDX_PORT_IN[2]) |=> (wb_ack_o
    && wb_dat_o == {24'h000000, $past(pad_din[2])}))
    else $error("port C input read wrong");

  a_change_evt: assert property ((pc_raw != '0) |=> pin_change_evt == $past(pc_raw))
    else $error("pin change not signalled");

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_stat_clear: assert property ((rd && idx == gpr_pkg::IDX_IRQ_STAT && pc_raw == '0) |=> r.stat == '0)
    else $error("status read did not clear");

  // Bus timing, sticky status and input-buffer gating
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");

  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data left on the bus outside an answer");

  a_stat_sticky: assert property (!(rd && idx == gpr_pkg::IDX_IRQ_STAT) |=>
    ((r.stat & $past(r.stat)) == $past(r.stat)))
    else $error("status bit lost without a clearing read");

  a_ie_free: assert property ((!r.pc_ge && !sleep_mode) |-> pad_din[gpr_pkg::AUX_PAD] == aux_stable)
    else $error("aux input gated while group enable is off");

  a_aux_in_read: assert property ((rd && idx == gpr_pkg::IDX_AUX_IN && r.pc_ge) |=>
    ((wb_dat_o[gpr_pkg::PC_NUM-1:0] & $past(r.pc_mask)) == 7'h00))
    else $error("enabled pin-change input visible on the bus");

  a_sleep_off: assert property (sleep_mode |-> pad_din[gpr_pkg::NUM_PORTS-1:0] == '0)
    else $error("port input seen while asleep");

  c_pin_change: cover property (pin_change_evt != '0);
  c_irq_rise: cover property ($rose(irq));
  c_bus_write: cover property (wb_ack_o && $past(wb_we_i));
  c_set_clear: cover property (rd && idx == gpr_pkg::IDX_IRQ_STAT && pc_raw != '0);
  c_sleep_read: cover property (sleep_mode && rd);

endmodule

// file: src/gpr_pkg.sv
// Constants, register map and state layout of the GPIO port register block
package gpr_pkg;

  // Bus and port geometry
  localparam int unsigned ADR_W = 10;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned NUM_PADS = 5;
  localparam int unsigned AUX_PAD = 4;
  localparam int unsigned SYNC_W = 40;

  // Pin-change source numbering
  localparam int unsigned PC_NUM = 7;
  localparam int unsigned PC_SRC_FIRST = 24;
  localparam int unsigned PC_SRC_LAST = 30;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PORT_IN [NUM_PORTS] = '{8'h00, 8'h03, 8'h06, 8'h09};
  localparam logic [IDX_W-1:0] IDX_PORT_DIR [NUM_PORTS] = '{8'h01, 8'h04, 8'h07, 8'h0A};
  localparam logic [IDX_W-1:0] IDX_PORT_OUT [NUM_PORTS] = '{8'h02, 8'h05, 8'h08, 8'h0B};
  localparam logic [IDX_W-1:0] IDX_CTRL = 8'h35;
  localparam logic [IDX_W-1:0] IDX_AUX_IN = 8'h40;
  localparam logic [IDX_W-1:0] IDX_AUX_DIR = 8'h41;
  localparam logic [IDX_W-1:0] IDX_AUX_OUT = 8'h42;
  localparam logic [IDX_W-1:0] IDX_PC_MASK = 8'h43;
  localparam logic [IDX_W-1:0] IDX_PC_CTRL = 8'h44;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h45;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h46;

  // Control register fields
  localparam int unsigned CTRL_DBG_BIT = 7;
  localparam int unsigned CTRL_PULLUP_KILL_BIT = 4;
  localparam int unsigned CTRL_VSEL_BIT = 1;
  localparam int unsigned CTRL_VCE_BIT = 0;
  localparam logic [PORT_W-1:0] CTRL_RW_MASK = 8'h93;
  localparam logic [PORT_W-1:0] AUX_RW_MASK = 8'h7F;
  localparam int unsigned PC_GE_BIT = 0;

  // Reset values
  localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;
  localparam logic [PORT_W-1:0] CTRL_RESET = 8'h00;

  // Complete state of the top module
  typedef struct packed {
    logic [NUM_PORTS-1:0][PORT_W-1:0] out;
    logic [NUM_PORTS-1:0][PORT_W-1:0] dir;
    logic [PORT_W-1:0] aux_out;
    logic [PORT_W-1:0] aux_dir;
    logic [PORT_W-1:0] ctrl;
    logic [PC_NUM-1:0] pc_mask;
    logic pc_ge;
    logic [PC_NUM-1:0] stat;
    logic [PC_NUM-1:0] imask;
    logic [PC_NUM-1:0] aux_prev;
    logic [PC_NUM-1:0] evt;
    logic ack;
    logic [DAT_W-1:0] rdat;
  } gpr_regs_s;

endpackage

// file: src/gpr_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module gpr_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Raw pins and settled levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] settled
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } gpr_sync_s;

  gpr_sync_s r;
  gpr_sync_s n;

  // Shift chain; a level is taken once stages two and three agree
  always_comb begin
    n = r;
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.stable = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.stable);
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign settled = r.stable;

endmodule

// file: src/gpr_pad.sv
// Per-pin override and pull-up logic of one eight-bit port
`timescale 1ns/10ps
module gpr_pad (
  // Register side
  input wire logic [7:0] direction_bit,
  input wire logic [7:0] output_latch_bit,
  input wire logic pullup_kill_bit,
  input wire logic sleep_mode,
  // Alternate-function overrides
  input wire logic [7:0] pullup_override_enable,
  input wire logic [7:0] pullup_override_value,
  input wire logic [7:0] direction_override_enable,
  input wire logic [7:0] direction_override_value,
  input wire logic [7:0] outval_override_enable,
  input wire logic [7:0] outval_override_value,
  input wire logic [7:0] input_enable_override_enable,
  input wire logic [7:0] input_enable_override_value,
  // Pin side
  input wire logic [7:0] pin_level,
  output logic [7:0] pin_drive,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  output logic [7:0] pin_din
);

  // One slice per pin
  for (genvar b = 0; b < 8; b++) begin : g_bit
    logic dir_eff;
    logic in_en;
    assign dir_eff = direction_override_enable[b] ? direction_override_value[b] : direction_bit[b];
    assign pin_oe[b] = dir_eff;
    assign pin_drive[b] = outval_override_enable[b] ? outval_override_value[b] : output_latch_bit[b];
    // Pull-up from the override value when enabled, else only for an input with latch high and never while killed
    assign pin_pullup[b] = pullup_override_enable[b] ? pullup_override_value[b] :
                           (~direction_bit[b] & output_latch_bit[b] & ~pullup_kill_bit);
    assign in_en = input_enable_override_enable[b] ? input_enable_override_value[b] : ~sleep_mode;
    assign pin_din[b] = pin_level[b] & in_en;
  end

endmodule

// file: sim/gpr_pins.sv
// Pin-side model: resolves each pad from design drive, pull-up and an external driver
`timescale 1ns/10ps
module gpr_pins (
  // Clock
  input wire logic sys_clk,
  // Design side of the pads
  input wire logic [7:0] drive,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull_en,
  // External driver
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved pad level
  output logic [7:0] level
);
  logic [7:0] float_q = 8'h55;

  // A floating pad shows a pattern that changes every cycle
  always @(posedge sys_clk) float_q <= ~float_q;

  // Design drive wins, then the external driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) level[i] = drive[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pull_en[i]) level[i] = 1'b1;
      else level[i] = float_q[i];
    end
  end
endmodule

// file: sim/gpr_top_test.sv
// Self-checking testbench of the GPIO port register block
`timescale 1ns/10ps
module gpr_top_test;
  logic sys_clk;
  logic rst_n;
  logic wb_cyc, wb_stb, wb_we, wb_ack, sleep_mode, irq, dbg_dis, vsel, vce;
  logic [gpr_pkg::ADR_W-1:0] wb_adr;
  logic [gpr_pkg::SEL_W-1:0] wb_sel;
  logic [gpr_pkg::DAT_W-1:0] wb_dat, wb_rdat;
  logic [7:0] pin [5];
  logic [7:0] drv [5];
  logic [7:0] oe [5];
  logic [7:0] pu [5];
  logic [7:0] ext_en [5];
  logic [7:0] ext_val [5];
  logic [gpr_pkg::PC_NUM-1:0] evt;
  int num_errors;
  int checked;

  gpr_top i_gpr_top (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .port_a_pin(pin[0]), .port_a_drive(drv[0]), .port_a_oe(oe[0]), .port_a_pullup(pu[0]),
    .port_b_pin(pin[1]), .port_b_drive(drv[1]), .port_b_oe(oe[1]), .port_b_pullup(pu[1]),
    .port_c_pin(pin[2]), .port_c_drive(drv[2]), .port_c_oe(oe[2]), .port_c_pullup(pu[2]),
    .port_d_pin(pin[3]), .port_d_drive(drv[3]), .port_d_oe(oe[3]), .port_d_pullup(pu[3]),
    .aux_pin(pin[4]), .aux_drive(drv[4]), .aux_oe(oe[4]), .aux_pullup(pu[4]), .sleep_mode(sleep_mode),
    .pin_change_evt(evt), .irq(irq), .debug_port_disable(dbg_dis), .vector_table_select(vsel),
    .vector_change_enable(vce));

  // One pad model per port
  for (genvar g = 0; g < 5; g++) begin : g_pad
    gpr_pins i_gpr_pins (.sys_clk(sys_clk), .drive(drv[g]), .oe(oe[g]), .pull_en(pu[g]),
      .ext_en(ext_en[g]), .ext_val(ext_val[g]), .level(pin[g]));
  end

  // Clock at 20 MHz
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic [7:0] idx, input logic we, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'hF;
    wb_dat <= {24'h000000, wd};
    n = 0;
    // Only the watchdog ends a wait; the answer must come one cycle after the take
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1);
    chk(n, 2);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(idx, 1'b1, d, r);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] r;
    wb(idx, 1'b0, 8'h00, r);
    chk(r, e);
  endtask

  task automatic t_reset;
    for (int p = 0; p < 4; p++) begin
      rdc(gpr_pkg::IDX_PORT_DIR[p], 32'h0);
      rdc(gpr_pkg::IDX_PORT_OUT[p], 32'h0);
      chk(oe[p], 8'h00);
    end
    rdc(gpr_pkg::IDX_CTRL, 32'h0);
    wr(8'h20, 8'hFF);
    rdc(8'h20, 32'h0);
  endtask

  // Direction, latch and pin readback on ports A to D
  task automatic t_ports;
    logic [7:0] d, o;
    for (int p = 0; p < 4; p++) begin
      d = 8'(8'hA5 ^ p);
      o = 8'(8'h3C + p);
      wr(gpr_pkg::IDX_PORT_DIR[p], d);
      wr(gpr_pkg::IDX_PORT_OUT[p], o);
      repeat (6) @(posedge sys_clk);
      rdc(gpr_pkg::IDX_PORT_DIR[p], {24'h0, d});
      rdc(gpr_pkg::IDX_PORT_OUT[p], {24'h0, o});
      chk(oe[p], d);
      chk(drv[p], o);
      rdc(gpr_pkg::IDX_PORT_IN[p], {24'h0, (o & d) | (8'h96 & ~d)});
    end
    wr(gpr_pkg::IDX_PORT_IN[0], 8'h0F);
    rdc(gpr_pkg::IDX_PORT_OUT[0], 32'h33);
  endtask

  // Pull-up kill and the control register access kinds
  task automatic t_pullup;
    wr(gpr_pkg::IDX_PORT_DIR[1], 8'h00);
    wr(gpr_pkg::IDX_PORT_OUT[1], 8'hFF);
    repeat (2) @(posedge sys_clk);
    chk(pu[1], 8'hFF);
    wr(gpr_pkg::IDX_CTRL, 8'hFF);
    rdc(gpr_pkg::IDX_CTRL, 32'h93);
    chk(pu[1], 8'h00);
    chk({dbg_dis, vsel, vce}, 3'b111);
    wr(gpr_pkg::IDX_CTRL, 8'h6C);
    rdc(gpr_pkg::IDX_CTRL, 32'h0);
    chk(pu[1], 8'hFF);
  endtask

  // Aux port overrides under pin-change masks
  task automatic t_aux;
    wr(gpr_pkg::IDX_AUX_DIR, 8'h00);
    wr(gpr_pkg::IDX_AUX_OUT, 8'hFF);
    wr(gpr_pkg::IDX_PC_MASK, 8'h7F);
    wr(gpr_pkg::IDX_PC_CTRL, 8'h01);
    repeat (6) @(posedge sys_clk);
    chk(pu[4], 8'h7F);
    chk(oe[4], 8'h00);
    rdc(gpr_pkg::IDX_AUX_IN, 32'h00);
    wr(gpr_pkg::IDX_PC_MASK, 8'h0F);
    repeat (6) @(posedge sys_clk);
    rdc(gpr_pkg::IDX_AUX_IN, 32'h70);
    wr(gpr_pkg::IDX_PC_CTRL, 8'h00);
    repeat (6) @(posedge sys_clk);
    rdc(gpr_pkg::IDX_AUX_IN, 32'h7E);
    // Asleep: input buffers off, so port and aux inputs read zero
    sleep_mode <= 1'b1;
    rdc(gpr_pkg::IDX_PORT_IN[0], 32'h0);
    rdc(gpr_pkg::IDX_AUX_IN, 32'h0);
    sleep_mode <= 1'b0;
  endtask

  // Each source toggled once; events, status, mask and irq
  task automatic t_irq;
    logic [6:0] seen;
    wr(gpr_pkg::IDX_PC_MASK, 8'h05);
    wr(gpr_pkg::IDX_PC_CTRL, 8'h01);
    wr(gpr_pkg::IDX_IRQ_MASK, 8'h01);
    repeat (8) @(posedge sys_clk);
    rdc(gpr_pkg::IDX_IRQ_STAT, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    for (int b = 0; b < 7; b++) begin
      ext_val[4][b] <= ~ext_val[4][b];
      seen = '0;
      repeat (10) begin
        @(posedge sys_clk);
        seen |= evt;
      end
      chk(seen, 7'(7'h05 & (7'h01 << b)));
      chk(irq, b == 0);
      rdc(gpr_pkg::IDX_IRQ_STAT, 32'(7'h05 & (7'h01 << b)));
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0);
    end
  endtask

  task automatic end_of_test;
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    checked = 0;
    rst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, sleep_mode} = 4'h0;
    wb_adr = '0;
    wb_sel = '0;
    wb_dat = '0;
    for (int p = 0; p < 5; p++) begin
      ext_en[p] = 8'hFF;
      ext_val[p] = (p == 4) ? 8'hFE : 8'h96;
    end
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_ports();
    t_pullup();
    t_aux();
    t_irq();
    end_of_test();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
endmodule
